// ===== src/itr_regs.vh
`ifndef ITR_REGS_VH
`define ITR_REGS_VH
// What this block does
// R1 - Setting read uses write then repeated start
// R2 - Gate pin held high while reading settings
// R3 - Target address 0110010, write bit first
// R4 - Pointer byte bit 7 zero selects settings
// R5 - Pointer byte bit 0 always sent one
// R6 - Device shifts setting bytes out MSB first
// R7 - Last read byte not acknowledged, then stop
// R8 - Bytes past the second read all ones
// R9 - Stop clears pointer, later reads give time
// R10 - No stop between pointer write and read
// R11 - Gate pin never resets the serial interface
// R12 - Device ignores start/stop while driving low
// R13 - Recovery: start, nine released clocks, stop
// R14 - Recovery runs at system initialisation
// R15 - Gate low at power-up asserts oscillation start
// R16 - Oscillation start clears within 500 ms
// R17 - Gate held low 500 ms asserts oscillation start
// R18 - Start and stop are data edges, clock high
// R19 - Receiver acknowledges low on ninth clock
// R20 - Device releases data outside its own bits

// Register byte offsets on the bus
`define ITR_OFF_CMD     8'h00
`define ITR_OFF_GATE    8'h04
`define ITR_OFF_STATUS  8'h08
`define ITR_OFF_RDATA   8'h0c
`define ITR_OFF_WDATA   8'h10

// Command codes written to the command register
`define ITR_CMD_NONE    3'h0
`define ITR_CMD_RD_SET  3'h1
`define ITR_CMD_RD_TIME 3'h2
`define ITR_CMD_WR_SET  3'h3
`define ITR_CMD_RECOVER 3'h4
`define ITR_CMD_OSC     3'h5

// Status bit positions
`define ITR_ST_BUSY     0
`define ITR_ST_NACK     1
`define ITR_ST_DONE     2

// Reset values
`define ITR_GATE_RST    1'b1
`define ITR_WDATA_RST   16'h0000

// Serial framing
`define ITR_TARGET_ADDR 7'h32
`define ITR_POINTER     8'h01

// Timing
`define ITR_CLK_KHZ     125000
`define ITR_SCL_KHZ     100
`define ITR_OSC_MS      500
`define ITR_QUARTER_CYCLES ((`ITR_CLK_KHZ + 4 * `ITR_SCL_KHZ - 1) / (4 * `ITR_SCL_KHZ))
`define ITR_OSC_CYCLES  (`ITR_OSC_MS * `ITR_CLK_KHZ)
`endif

// ===== src/itr_tick.v
`timescale 1ns/10ps
// Quarter-bit strobe; restarts whenever run drops so phases stay aligned
module itr_tick #(
  parameter CYCLES = 313
) (
  // Clock and reset
  input  wire clk_in,
  input  wire reset_in,
  // Control
  input  wire run_in,
  output reg  tick_out
);
  reg [31:0] count;

  always @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      count    <= 32'h0;
      tick_out <= 1'b0;
    end else if (count == CYCLES - 1) begin
      count    <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      count    <= count + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule // itr_tick

// ===== src/itr_ctrl.v
`timescale 1ns/10ps
`include "itr_regs.vh"
module itr_ctrl #(
  parameter QUARTER_CYCLES = `ITR_QUARTER_CYCLES,
  parameter OSC_CYCLES     = `ITR_OSC_CYCLES
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [31:0] hrdata_out,
  // Two-wire bus, open drain
  input  wire        scl_in,
  output wire        scl_out,
  output reg         scl_oe_n_out,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe_n_out,
  // Gate pin of the timer
  output reg         output_gate_pin_out
);
  localparam S_IDLE = 5'b00001;
  localparam S_NEXT = 5'b00010;
  localparam S_COND = 5'b00100;
  localparam S_BITS = 5'b01000;
  localparam S_GATE = 5'b10000;

  localparam A_START = 3'h0;
  localparam A_TX    = 3'h1;
  localparam A_RXA   = 3'h2;
  localparam A_RXN   = 3'h3;
  localparam A_STOP  = 3'h4;

  localparam [7:0] ADDR_W = {`ITR_TARGET_ADDR, 1'b0};
  localparam [7:0] ADDR_R = {`ITR_TARGET_ADDR, 1'b1};

  reg  [4:0]  state;
  reg  [2:0]  cmd;
  reg  [3:0]  step;
  reg  [1:0]  q;
  reg  [3:0]  bitcnt;
  reg  [7:0]  shift;
  reg         abort;
  reg         boot_recover;
  reg         flag_nack;
  reg         flag_done;
  reg  [23:0] rdata;
  reg  [15:0] wdata;
  reg         gate_level;
  reg         osc_low;
  reg  [31:0] osc_cnt;
  reg         a_wr;
  reg         a_rd;
  reg  [7:0]  a_addr;
  reg         rd_stage;
  wire        tick;
  wire        busy;
  wire        cmd_wr;
  wire        status_wr;
  wire        cmd_ok;
  wire        go;
  wire [2:0]  go_cmd;
  wire [2:0]  cur_act;
  wire        bit_val;
  wire        ack_bit;
  wire        rx_act;

  // Action sequence of each command
  function [2:0] step_act;
    input [2:0] c;
    input [3:0] s;
    begin
      step_act = A_STOP;
      if (c == `ITR_CMD_RD_SET) begin
        case (s)
          4'h0: step_act = A_START;
          4'h1: step_act = A_TX;
          4'h2: step_act = A_TX;
          4'h3: step_act = A_START; // R1 R10
          4'h4: step_act = A_TX;
          4'h5: step_act = A_RXA;
          4'h6: step_act = A_RXN; // R7 R8
          default: step_act = A_STOP;
        endcase
      end else if (c == `ITR_CMD_RD_TIME) begin
        case (s)
          4'h0: step_act = A_START;
          4'h1: step_act = A_TX;
          4'h2: step_act = A_RXA;
          4'h3: step_act = A_RXA;
          4'h4: step_act = A_RXN; // R7
          default: step_act = A_STOP;
        endcase
      end else if (c == `ITR_CMD_WR_SET) begin
        case (s)
          4'h0: step_act = A_START;
          4'h1: step_act = A_TX;
          4'h2: step_act = A_TX;
          4'h3: step_act = A_TX;
          4'h4: step_act = A_TX;
          default: step_act = A_STOP;
        endcase
      end else if (c == `ITR_CMD_RECOVER) begin
        case (s)
          4'h0: step_act = A_START;
          4'h1: step_act = A_RXN; // R12 R13
          default: step_act = A_STOP;
        endcase
      end
    end
  endfunction

  // Byte sent by each transmit step
  function [7:0] step_byte;
    input [2:0]  c;
    input [3:0]  s;
    input [15:0] w;
    begin
      step_byte = 8'hff;
      if (s == 4'h1) begin
        step_byte = (c == `ITR_CMD_RD_TIME) ? ADDR_R : ADDR_W; // R3
      end else if (s == 4'h2) begin
        step_byte = `ITR_POINTER; // R4 R5
      end else if (s == 4'h3) begin
        step_byte = w[15:8];
      end else if (s == 4'h4) begin
        step_byte = (c == `ITR_CMD_RD_SET) ? ADDR_R : w[7:0];
      end
    end
  endfunction

  itr_tick #(
    .CYCLES (QUARTER_CYCLES)
  ) u_tick (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .run_in   (state == S_COND || state == S_BITS),
    .tick_out (tick)
  );

  assign busy      = (state != S_IDLE);
  assign cur_act   = abort ? A_STOP : step_act(cmd, step);
  assign rx_act    = (cur_act == A_RXA) || (cur_act == A_RXN);
  // Ninth bit: release after sending, pull low to acknowledge each read byte but the last
  assign ack_bit   = (cur_act == A_RXA) ? 1'b0 : 1'b1; // R19
  assign bit_val   = (bitcnt == 4'h8) ? ack_bit : (rx_act ? 1'b1 : shift[7]);
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;

  // Bus slave
  assign hreadyout_out = !rd_stage;
  assign hresp_out     = 1'b0;
  assign cmd_ok        = (hwdata_in[2:0] != `ITR_CMD_NONE) && (hwdata_in[2:0] <= `ITR_CMD_OSC);
  assign cmd_wr        = a_wr && (a_addr == `ITR_OFF_CMD) && cmd_ok;
  assign status_wr     = a_wr && (a_addr == `ITR_OFF_STATUS);
  // Commands written while busy are dropped
  assign go            = !busy && (boot_recover || cmd_wr);
  assign go_cmd        = boot_recover ? `ITR_CMD_RECOVER : hwdata_in[2:0]; // R14

  always @(posedge clk_in) begin
    if (reset_in) begin
      a_wr     <= 1'b0;
      a_rd     <= 1'b0;
      a_addr   <= 8'h00;
      rd_stage <= 1'b0;
    end else begin
      rd_stage <= 1'b0;
      if (hready_in) begin
        a_wr   <= hsel_in && htrans_in[1] && hwrite_in;
        a_rd   <= hsel_in && htrans_in[1] && !hwrite_in;
        a_addr <= {haddr_in[7:2], 2'b00};
        if (hsel_in && htrans_in[1] && !hwrite_in) begin
          rd_stage <= 1'b1;
        end
      end
    end
  end

  // One wait state lets read data come straight from a flop
  always @(posedge clk_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h0;
    end else if (rd_stage && a_rd) begin
      if (a_addr == `ITR_OFF_CMD) begin
        hrdata_out <= {29'h0, cmd};
      end else if (a_addr == `ITR_OFF_GATE) begin
        hrdata_out <= {31'h0, gate_level};
      end else if (a_addr == `ITR_OFF_STATUS) begin
        hrdata_out <= {29'h0, flag_done, flag_nack, busy};
      end else if (a_addr == `ITR_OFF_RDATA) begin
        hrdata_out <= {8'h00, rdata};
      end else if (a_addr == `ITR_OFF_WDATA) begin
        hrdata_out <= {16'h0, wdata};
      end else begin
        hrdata_out <= 32'h0;
      end
    end
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      gate_level <= `ITR_GATE_RST;
      wdata      <= `ITR_WDATA_RST;
    end else if (a_wr) begin
      if (a_addr == `ITR_OFF_GATE) begin
        gate_level <= hwdata_in[0];
      end else if (a_addr == `ITR_OFF_WDATA) begin
        wdata <= hwdata_in[15:0];
      end
    end
  end

  // Gate pin: forced high for setting reads, low during oscillation start
  always @(posedge clk_in) begin
    if (reset_in) begin
      output_gate_pin_out <= `ITR_GATE_RST;
    end else if (busy && cmd == `ITR_CMD_RD_SET) begin
      output_gate_pin_out <= 1'b1; // R2
    end else if (state == S_GATE && osc_low) begin
      output_gate_pin_out <= 1'b0; // R15 R17
    end else begin
      output_gate_pin_out <= gate_level;
    end
  end

  // Command sequencer and bit engine
  always @(posedge clk_in) begin
    if (reset_in) begin
      state        <= S_IDLE;
      cmd          <= `ITR_CMD_NONE;
      step         <= 4'h0;
      q            <= 2'h0;
      bitcnt       <= 4'h0;
      shift        <= 8'h00;
      abort        <= 1'b0;
      boot_recover <= 1'b1;
      flag_nack    <= 1'b0;
      flag_done    <= 1'b0;
      rdata        <= 24'h0;
      osc_low      <= 1'b0;
      osc_cnt      <= 32'h0;
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end else begin
      // Clear by writing one; a new event in the same cycle wins below
      if (status_wr && hwdata_in[`ITR_ST_NACK]) begin
        flag_nack <= 1'b0;
      end
      if (status_wr && hwdata_in[`ITR_ST_DONE]) begin
        flag_done <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          scl_oe_n_out <= 1'b1;
          sda_oe_n_out <= 1'b1; // R20
          if (go) begin
            boot_recover <= 1'b0;
            cmd          <= go_cmd;
            step         <= 4'h0;
            abort        <= 1'b0;
            osc_low      <= 1'b1;
            osc_cnt      <= 32'h0;
            if (go_cmd == `ITR_CMD_RD_SET || go_cmd == `ITR_CMD_RD_TIME) begin
              rdata <= 24'h0;
            end
            state <= (go_cmd == `ITR_CMD_OSC) ? S_GATE : S_NEXT;
          end
        end
        S_NEXT: begin
          q      <= 2'h0;
          bitcnt <= 4'h0;
          shift  <= step_byte(cmd, step, wdata);
          state  <= (cur_act == A_START || cur_act == A_STOP) ? S_COND : S_BITS;
        end
        S_COND: begin
          // Clock stretching: phase 2 waits for the clock to read high
          if (tick && !(q == 2'h2 && !scl_in)) begin
            q <= q + 2'h1;
            if (cur_act == A_START) begin
              case (q)
                2'h0: sda_oe_n_out <= 1'b1;
                2'h1: scl_oe_n_out <= 1'b1;
                2'h2: sda_oe_n_out <= 1'b0; // R18
                default: scl_oe_n_out <= 1'b0;
              endcase
            end else begin
              case (q)
                2'h0: sda_oe_n_out <= 1'b0;
                2'h1: scl_oe_n_out <= 1'b1;
                2'h2: sda_oe_n_out <= 1'b1; // R9 R11 R18
                default: sda_oe_n_out <= 1'b1;
              endcase
            end
            if (q == 2'h3) begin
              step <= step + 4'h1;
              if (cur_act == A_STOP) begin
                state     <= S_IDLE;
                flag_done <= 1'b1;
              end else begin
                state <= S_NEXT;
              end
            end
          end
        end
        S_BITS: begin
          if (tick && !(q == 2'h2 && !scl_in)) begin
            q <= q + 2'h1;
            case (q)
              2'h0: begin
                scl_oe_n_out <= 1'b0;
                sda_oe_n_out <= bit_val;
              end
              2'h1: scl_oe_n_out <= 1'b1;
              2'h2: begin
                if (bitcnt == 4'h8) begin
                  if (cur_act == A_TX && sda_in) begin
                    abort     <= 1'b1;
                    flag_nack <= 1'b1;
                  end
                end else begin
                  shift <= {shift[6:0], sda_in}; // R6
                end
              end
              default: begin
                scl_oe_n_out <= 1'b0;
                bitcnt       <= bitcnt + 4'h1;
                if (bitcnt == 4'h8) begin
                  // Data stays put on the falling clock; the next q0 moves it (hold time)
                  step         <= step + 4'h1;
                  state        <= S_NEXT;
                  if (rx_act && cmd != `ITR_CMD_RECOVER) begin
                    rdata <= {rdata[15:0], shift};
                  end
                end
              end
            endcase
          end
        end
        S_GATE: begin
          // Low for the hold time, then at the gate register level while the device settles
          if (osc_cnt == OSC_CYCLES - 1) begin
            osc_cnt <= 32'h0;
            if (osc_low) begin
              osc_low <= 1'b0; // R17
            end else begin
              state     <= S_IDLE; // R16
              flag_done <= 1'b1;
            end
          end else begin
            osc_cnt <= osc_cnt + 32'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // itr_ctrl

// ===== bench/itr_ctrl_assertions.sv
`timescale 1ns/10ps
module itr_ctrl_assertions #(
  parameter OSC_CYCLES = 20
) (
  input wire        clk_in,
  input wire        reset_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire [31:0] hwdata_in,
  input wire        hready_in,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire        scl_oe_n_out,
  input wire        sda_oe_n_out,
  input wire        output_gate_pin_out
);
  reg        scl_q;
  reg        sda_q;
  reg        cw;
  reg        set_rd;
  reg        osc_act;
  reg [1:0]  n_start;
  reg [31:0] lo_cnt;
  wire       taken   = hsel_in && hready_in && htrans_in[1];
  wire       start_w = scl_oe_n_out && scl_q && sda_q && !sda_oe_n_out;
  wire       stop_w  = scl_oe_n_out && scl_q && !sda_q && sda_oe_n_out;
  wire       rise_w  = osc_act && output_gate_pin_out && lo_cnt != 32'h0;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Command decode assumes commands are only written while the block is idle
  always @(posedge clk_in) begin
    scl_q  <= scl_oe_n_out;
    sda_q  <= sda_oe_n_out;
    cw     <= taken && hwrite_in && haddr_in[7:2] == 6'h00;
    lo_cnt <= output_gate_pin_out ? 32'h0 : lo_cnt + 32'h1;
    if (reset_in || cw) n_start <= 2'h0;
    else if (start_w) n_start <= n_start + 2'h1;
    if (reset_in || stop_w) set_rd <= 1'b0;
    else if (cw) set_rd <= hwdata_in[2:0] == 3'h1;
    if (reset_in || rise_w) osc_act <= 1'b0;
    else if (cw && hwdata_in[2:0] == 3'h5) osc_act <= 1'b1;
  end
  sequence start_s;
    scl_oe_n_out && $past(scl_oe_n_out) && $fell(sda_oe_n_out);
  endsequence
  sequence rd_data_s;
    !hreadyout_out ##1 hreadyout_out;
  endsequence
  init_recover_a: assert property ($fell(reset_in) |-> ##[1:60] start_s)
    else $error("no start after reset release");
  rpt_start_a: assert property (set_rd && stop_w |-> n_start == 2'h2)
    else $error("setting read without exactly one repeated start");
  gate_high_a: assert property (set_rd && !sda_oe_n_out |-> output_gate_pin_out)
    else $error("gate pin low during setting read");
  osc_low_a: assert property ($rose(osc_act) |-> ##[0:4] !output_gate_pin_out)
    else $error("gate pin not lowered for oscillation start");
  osc_hold_a: assert property (rise_w |-> lo_cnt >= OSC_CYCLES)
    else $error("gate pin low too short");
  read_wait_a: assert property (taken && !hwrite_in |=> rd_data_s)
    else $error("read data phase not two cycles");
  write_fast_a: assert property (taken && hwrite_in |=> hreadyout_out)
    else $error("write data phase stalled");
  resp_okay_a: assert property (hresp_out == 1'b0)
    else $error("error response");
endmodule // itr_ctrl_assertions

bind itr_ctrl itr_ctrl_assertions #(.OSC_CYCLES(OSC_CYCLES)) u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out),
  .output_gate_pin_out(output_gate_pin_out));

// ===== bench/itr_dev_model.sv
`timescale 1ns/10ps
module itr_dev_model #(
  parameter [15:0] SET_VAL  = 16'ha5c3,
  parameter [23:0] TIME_VAL = 24'h005a96
) (
  // Bus levels and gate pin
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       gate_in,
  // Data pull, oscillation start, observations
  output reg        pull_out,
  output reg        osc_out,
  output reg  [7:0] ptr_out,
  output reg        nak_out
);
  reg [7:0] sh;
  reg [7:0] ob;
  reg [3:0] bc;
  reg [1:0] ph;
  reg [2:0] idx;
  reg       act, rdm, tx, sel;
  initial begin
    pull_out = 1'b0;
    act = 1'b0;
    sel = 1'b0;
    ptr_out = 8'h00;
    nak_out = 1'b0;
  end
  function [7:0] byte_f(input [2:0] i);
    if (sel && gate_in) byte_f = (i < 3'h2) ? SET_VAL[15 - 8 * i -: 8] : 8'hff;
    else byte_f = (i < 3'h3) ? TIME_VAL[23 - 8 * i -: 8] : 8'hff;
  endfunction
  always @(gate_in) osc_out = !gate_in;
  // A held-low line hides both conditions, as on the real part
  always @(negedge sda_in) if (scl_in && !pull_out) begin
    act = 1'b1;
    // The start's own falling clock is not a data bit
    bc = 4'hf;
    ph = 2'h0;
    rdm = 1'b0;
    tx = 1'b0;
  end
  always @(posedge sda_in) if (scl_in && !pull_out) begin
    act = 1'b0;
    sel = 1'b0;
  end
  always @(posedge scl_in) if (act) begin
    if (!tx && bc < 4'h8) sh = {sh[6:0], sda_in};
    if (tx && bc == 4'h8) begin
      nak_out = sda_in;
      act = !sda_in;
    end
  end
  always @(negedge scl_in) if (act) begin
    if (bc == 4'hf) bc = 4'h0;
    else if (bc == 4'h8) begin
      bc = 4'h0;
      pull_out = 1'b0;
      tx = rdm;
      if (tx) begin
        ob = byte_f(idx);
        idx = idx + 3'h1;
        pull_out = !ob[7];
      end
    end else begin
      bc = bc + 4'h1;
      if (bc == 4'h8 && !tx) begin
        if (ph == 2'h0) begin
          act = sh[7:1] == 7'h32;
          rdm = sh[0];
          idx = 3'h0;
        end
        if (ph == 2'h1) begin
          ptr_out = sh;
          sel = !sh[7];
        end
        if (ph != 2'h3) ph = ph + 2'h1;
        pull_out = act;
      end else if (tx) pull_out = bc != 4'h8 && !ob[3'h7 - bc[2:0]];
    end
  end
endmodule // itr_dev_model

// ===== bench/tb_interval_timer_i2c_readback.sv
`timescale 1ns/10ps
module tb_interval_timer_i2c_readback;
  localparam [15:0] SETV = 16'ha5c3;
  // First time byte is zero so the device holds the line low through it
  localparam [23:0] TIMV = 24'h005a96;
  reg         clk_in, reset_in, hsel_in, hwrite_in;
  reg  [1:0]  htrans_in;
  reg  [31:0] haddr_in, hwdata_in, rdq;
  wire        hreadyout_out, scl_oe_n_out, sda_oe_n_out, gate, pull, osc, nak;
  wire [31:0] hrdata_out;
  wire [7:0]  ptr;
  wire        scl_w = scl_oe_n_out;
  wire        sda_w = sda_oe_n_out & !pull;
  int         n_fail, cmp_count;

  itr_ctrl #(.QUARTER_CYCLES(4), .OSC_CYCLES(20)) u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(),
    .hrdata_out(hrdata_out), .scl_in(scl_w), .scl_out(), .scl_oe_n_out(scl_oe_n_out),
    .sda_in(sda_w), .sda_out(), .sda_oe_n_out(sda_oe_n_out), .output_gate_pin_out(gate));
  itr_dev_model #(.SET_VAL(SETV), .TIME_VAL(TIMV)) u_dev (
    .scl_in(scl_w), .sda_in(sda_w), .gate_in(gate), .pull_out(pull), .osc_out(osc),
    .ptr_out(ptr), .nak_out(nak));

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    hwrite_in <= w;
    htrans_in <= 2'h2;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (hreadyout_out !== 1'b1 && n < 20);
      if (hreadyout_out !== 1'b1) begin
        n_fail++;
        wrap_up;
      end
      if (k == 0) begin
        htrans_in <= 2'h0;
        hwdata_in <= d;
      end
    end
    rdq = hrdata_out;
  endtask
  task wait_idle;
    int n;
    n = 0;
    do begin
      ahb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rdq[0] !== 1'b0 && n < 3000);
    if (rdq[0] !== 1'b0) begin
      n_fail++;
      wrap_up;
    end
  endtask
  task t_reset;
    reset_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    wait_idle;
    chk(rdq[2:1], 2'b10, "recovery status");
    ahb(1'b1, 8'h08, 32'h6);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rdq, 32'h1, "gate reg");
    chk(gate, 1'b1, "gate pin");
  endtask
  task t_rd_set(input logic g);
    ahb(1'b1, 8'h04, {31'h0, g});
    ahb(1'b1, 8'h00, 32'h1);
    wait_idle;
    chk(rdq[2:1], 2'b10, "status");
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rdq, {16'h0, SETV}, "setting");
    chk(ptr[7], 1'b0, "pointer bit 7");
    chk(ptr[0], 1'b1, "pointer bit 0");
    chk(nak, 1'b1, "last ack");
    ahb(1'b1, 8'h08, 32'h6);
  endtask
  task t_rd_time;
    ahb(1'b1, 8'h00, 32'h2);
    wait_idle;
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rdq, {8'h0, TIMV}, "time");
    ahb(1'b1, 8'h14, 32'hffff);
    ahb(1'b0, 8'h14, 32'h0);
    chk(rdq, 32'h0, "unmapped");
  endtask
  task t_wr_set;
    ahb(1'b1, 8'h08, 32'h6);
    ahb(1'b1, 8'h00, 32'h7);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rdq, 32'h0, "refused cmd");
    ahb(1'b1, 8'h10, 32'h1234);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rdq, 32'h1234, "wdata");
    ahb(1'b1, 8'h00, 32'h3);
    wait_idle;
    chk(rdq[2:1], 2'b10, "write status");
    chk(ptr[0], 1'b1, "write pointer bit 0");
    ahb(1'b0, 8'h00, 32'h0);
    chk(rdq, 32'h3, "cmd reg");
    ahb(1'b1, 8'h08, 32'h6);
  endtask
  task t_osc;
    int n;
    ahb(1'b1, 8'h04, 32'h1);
    ahb(1'b1, 8'h00, 32'h5);
    n = 0;
    while (gate !== 1'b0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    chk(osc, 1'b1, "osc on");
    n = 0;
    while (gate === 1'b0 && n < 500) begin
      @(posedge clk_in);
      n++;
    end
    chk(n >= 20, 1'b1, "gate low time");
    chk(gate, 1'b1, "gate back high");
    wait_idle;
    chk(osc, 1'b0, "osc off");
  endtask
  // Reset lands while the device holds the data line low mid-byte
  task t_stuck;
    ahb(1'b1, 8'h00, 32'h2);
    repeat (220) @(posedge clk_in);
    t_reset;
    t_rd_set(1'b1);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    reset_in = 1'b1;
    hsel_in = 1'b0;
    hwrite_in = 1'b0;
    htrans_in = 2'h0;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    n_fail = 0;
    cmp_count = 0;
    t_reset;
    t_rd_set(1'b1);
    t_rd_set(1'b0);
    t_rd_time;
    t_wr_set;
    t_osc;
    t_stuck;
    wrap_up;
  end
endmodule // tb_interval_timer_i2c_readback
